// file: rtl/prc_pkg.sv
// Purpose: constants for the page-one power and routing configuration bank
// Assumes: 32-bit axi4-lite data, one byte register per aligned word
// Notes: offsets printed as indexes; byte address is four times the index
package prc_pkg;
    localparam int ADDR_W = 6;
    localparam logic [3:0] IDX_PAGE = 4'h0;
    localparam logic [3:0] IDX_REF = 4'h1;
    localparam logic [3:0] IDX_REG = 4'h2;
    localparam logic [3:0] IDX_PLAY = 4'h3;
    localparam logic [3:0] IDX_RSV_LO = 4'h4;
    localparam logic [3:0] IDX_RSV_HI = 4'h7;
    localparam logic [3:0] IDX_GAIN = 4'h8;
    localparam logic [3:0] IDX_OUT = 4'h9;
    localparam logic [3:0] IDX_CM = 4'ha;
    localparam logic [3:0] IDX_LAST = 4'ha;
    // field positions
    localparam int REF_MASTER = 4;
    localparam int REF_POR_PD = 3;
    localparam int REF_BG_PD = 1;
    localparam int REG_VSEL_LO = 4;
    localparam int REG_PLL_PD = 3;
    localparam int REG_SPARE = 2;
    localparam int REG_SHORT = 1;
    localparam int REG_STRAP = 0;
    localparam int PLAY_HP_MODE = 5;
    localparam int PLAY_TIER_LO = 2;
    localparam int GAIN_SS_DIS = 7;
    localparam int GAIN_SS_DBL = 6;
    localparam int OUT_HP_EN = 5;
    localparam int OUT_LEFT_EN = 1;
    localparam int OUT_RIGHT_EN = 0;
    localparam int CM_LOW_VCM = 6;
    localparam int CM_HALF_DRV = 2;
    // writable masks, reset values, tier codes and response codes
    localparam logic [7:0] MASK_REF = 8'h1a;
    localparam logic [7:0] MASK_REG = 8'h38;
    localparam logic [7:0] MASK_PLAY = 8'h3c;
    localparam logic [7:0] MASK_GAIN = 8'hc0;
    localparam logic [7:0] MASK_OUT = 8'h23;
    localparam logic [7:0] MASK_CM = 8'h44;
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [7:0] RST_REF = 8'h00;
    localparam logic [7:0] RST_REG = 8'h0c;
    localparam logic [7:0] RST_PLAY = 8'h00;
    localparam logic [7:0] RST_GAIN = 8'h00;
    localparam logic [7:0] RST_OUT = 8'h00;
    localparam logic [7:0] RST_CM = 8'h00;
    localparam logic [2:0] TIER_THREE_FOUR = 3'h0;
    localparam logic [2:0] TIER_TWO = 3'h1;
    localparam logic [2:0] TIER_ONE = 3'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : prc_pkg

// file: rtl/prc_sync2.sv
// Purpose: two-flop level synchroniser for pin inputs
// Assumes: destination clock is aclk
// Notes: first stage is read only by the second
`timescale 1ns/1ns
module prc_sync2 #(
    parameter int W = 2
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // synchronous reset, low
    input wire logic aclken, // clock enable
    input wire logic [W-1:0] d, // asynchronous level
    output logic [W-1:0] q // synchronised level
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } prc_sync_s;
    prc_sync_s st_r;
    prc_sync_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        if (aclken) begin
            st_nxt.meta = d;
            st_nxt.sync = st_r.meta;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign q = st_r.sync;
endmodule : prc_sync2

// file: rtl/prc_regs.sv
// Purpose: page-one power, reference, regulator and output configuration bank
// Assumes: axi4-lite slave, one write and one read at a time, pins asynchronous
// Notes: reserved bits read as reset values and ignore writes
`timescale 1ns/1ns
module prc_regs (
    input wire logic aclk, // 25 MHz clock
    input wire logic aresetn, // synchronous reset, low
    input wire logic aclken, // clock enable, freezes state when low
    input wire logic [prc_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [prc_pkg::ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic regulator_strap_pin, // strap pin level
    input wire logic analog_supply_short, // short detect from regulator
    output logic [7:0] page_select, // current page number
    output logic master_ref_en, // master reference enabled
    output logic por_pd, // power-on-reset circuit powered down
    output logic regulator_reference_cell_pd, // regulator bandgap powered down
    output logic [1:0] regulator_vsel, // analog regulator voltage code
    output logic pll_level_shift_pd, // pll and headphone shifters powered down
    output logic dac_high_perf, // dac in high-performance mode
    output logic [2:0] dac_processing_mode, // dac processing tier code
    output logic soft_step_dis, // gain soft-stepping disabled
    output logic soft_step_double, // soft-step time doubled
    output logic headphone_output_en, // headphone output powered up
    output logic left_analog_input_en, // left analog input enabled
    output logic right_analog_input_en, // right analog input enabled
    output logic low_common_mode, // common mode 0.75 V
    output logic headphone_half_drive // headphone half drive
);
    typedef struct packed {
        logic aw_held;
        logic [3:0] aw_idx;
        logic aw_bad;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [7:0] page;
        logic [7:0] refc;
        logic [7:0] regc;
        logic [7:0] play;
        logic [7:0] gain;
        logic [7:0] outc;
        logic [7:0] cm;
    } prc_state_s;

    prc_state_s st_r;
    prc_state_s st_nxt;
    logic [1:0] pins_sync;

    prc_sync2 #(.W(2)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .aclken(aclken),
        .d({analog_supply_short, regulator_strap_pin}),
        .q(pins_sync)
    );

    function automatic logic idx_bad(input logic [prc_pkg::ADDR_W-1:0] a);
        idx_bad = (a[1:0] != 2'h0) || (a[5:2] > prc_pkg::IDX_LAST);
    endfunction : idx_bad

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (nw & mask);
    endfunction : merge

    logic [7:0] regc_view;
    logic [7:0] rd_byte;
    logic [3:0] ar_idx;
    logic wr_go;
    logic wr_hit;

    always_comb begin
        regc_view = st_r.regc;
        regc_view[prc_pkg::REG_SHORT] = pins_sync[1];
        regc_view[prc_pkg::REG_STRAP] = pins_sync[0];
    end

    assign ar_idx = s_axi_araddr[5:2];

    always_comb begin
        case (ar_idx)
            prc_pkg::IDX_PAGE: rd_byte = st_r.page;
            prc_pkg::IDX_REF: rd_byte = st_r.refc;
            prc_pkg::IDX_REG: rd_byte = regc_view;
            prc_pkg::IDX_PLAY: rd_byte = st_r.play;
            prc_pkg::IDX_GAIN: rd_byte = st_r.gain;
            prc_pkg::IDX_OUT: rd_byte = st_r.outc;
            prc_pkg::IDX_CM: rd_byte = st_r.cm;
            default: rd_byte = 8'h00;
        endcase
    end

    // readies drop while disabled so no address or write-data handshake completes that the state ignores
    assign s_axi_awready = aclken && !st_r.aw_held && !st_r.bvalid;
    assign s_axi_wready = aclken && !st_r.w_held && !st_r.bvalid;
    assign s_axi_arready = aclken && !st_r.rvalid;
    assign wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    assign wr_hit = aclken && wr_go && !st_r.aw_bad && st_r.w_lane;

    always_comb begin
        st_nxt = st_r;
        if (aclken) begin
            if (s_axi_awvalid && s_axi_awready) begin
                st_nxt.aw_held = 1'b1;
                st_nxt.aw_idx = s_axi_awaddr[5:2];
                st_nxt.aw_bad = idx_bad(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                st_nxt.w_held = 1'b1;
                st_nxt.w_byte = s_axi_wdata[7:0];
                st_nxt.w_lane = s_axi_wstrb[0];
            end
            if (wr_go) begin
                st_nxt.aw_held = 1'b0;
                st_nxt.w_held = 1'b0;
                st_nxt.bvalid = 1'b1;
                st_nxt.bresp = st_r.aw_bad ? prc_pkg::RESP_SLVERR : prc_pkg::RESP_OKAY;
                if (!st_r.aw_bad && st_r.w_lane) begin
                    // reserved bits are outside each mask and keep reset value
                    case (st_r.aw_idx)
                        prc_pkg::IDX_PAGE: st_nxt.page = st_r.w_byte;
                        prc_pkg::IDX_REF: st_nxt.refc =
                            merge(st_r.refc, st_r.w_byte, prc_pkg::MASK_REF);
                        prc_pkg::IDX_REG: st_nxt.regc =
                            merge(st_r.regc, st_r.w_byte, prc_pkg::MASK_REG);
                        prc_pkg::IDX_PLAY: st_nxt.play =
                            merge(st_r.play, st_r.w_byte, prc_pkg::MASK_PLAY);
                        prc_pkg::IDX_GAIN: st_nxt.gain =
                            merge(st_r.gain, st_r.w_byte, prc_pkg::MASK_GAIN);
                        prc_pkg::IDX_OUT: st_nxt.outc =
                            merge(st_r.outc, st_r.w_byte, prc_pkg::MASK_OUT);
                        prc_pkg::IDX_CM: st_nxt.cm =
                            merge(st_r.cm, st_r.w_byte, prc_pkg::MASK_CM);
                        default: st_nxt.page = st_r.page;
                    endcase
                end
            end else if (st_r.bvalid && s_axi_bready) begin
                st_nxt.bvalid = 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                st_nxt.rvalid = 1'b1;
                st_nxt.rdata = idx_bad(s_axi_araddr) ? 8'h00 : rd_byte;
                st_nxt.rresp = idx_bad(s_axi_araddr) ? prc_pkg::RESP_SLVERR
                                                      : prc_pkg::RESP_OKAY;
            end else if (st_r.rvalid && s_axi_rready) begin
                st_nxt.rvalid = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.page <= prc_pkg::RST_PAGE;
            st_r.refc <= prc_pkg::RST_REF;
            st_r.regc <= prc_pkg::RST_REG;
            st_r.play <= prc_pkg::RST_PLAY;
            st_r.gain <= prc_pkg::RST_GAIN;
            st_r.outc <= prc_pkg::RST_OUT;
            st_r.cm <= prc_pkg::RST_CM;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = {24'h000000, st_r.rdata};

    assign page_select = st_r.page;
    assign master_ref_en = st_r.refc[prc_pkg::REF_MASTER];
    assign por_pd = st_r.refc[prc_pkg::REF_POR_PD];
    assign regulator_reference_cell_pd = st_r.refc[prc_pkg::REF_BG_PD];
    assign regulator_vsel = st_r.regc[prc_pkg::REG_VSEL_LO +: 2];
    assign pll_level_shift_pd = st_r.regc[prc_pkg::REG_PLL_PD];
    assign dac_high_perf = st_r.play[prc_pkg::PLAY_HP_MODE];
    assign dac_processing_mode = st_r.play[prc_pkg::PLAY_TIER_LO +: 3];
    assign soft_step_dis = st_r.gain[prc_pkg::GAIN_SS_DIS];
    assign soft_step_double = st_r.gain[prc_pkg::GAIN_SS_DBL];
    assign headphone_output_en = st_r.outc[prc_pkg::OUT_HP_EN];
    assign left_analog_input_en = st_r.outc[prc_pkg::OUT_LEFT_EN];
    assign right_analog_input_en = st_r.outc[prc_pkg::OUT_RIGHT_EN];
    assign low_common_mode = st_r.cm[prc_pkg::CM_LOW_VCM];
    assign headphone_half_drive = st_r.cm[prc_pkg::CM_HALF_DRV];

    // assertions
    property p_page_write;
        @(posedge aclk) disable iff (!aresetn)
        (aclken && wr_go && !st_r.aw_bad && st_r.w_lane && st_r.aw_idx == prc_pkg::IDX_PAGE)
        |=> (page_select == $past(st_r.w_byte));
    endproperty
    a_page_write: assert property (p_page_write) else $error("page write lost");

    property p_ref_reserved;
        @(posedge aclk) disable iff (!aresetn)
        (st_r.refc & ~prc_pkg::MASK_REF) == 8'h00;
    endproperty
    a_ref_reserved: assert property (p_ref_reserved) else $error("ref reserved changed");

    property p_pll_reset;
        @(posedge aclk) $fell(aresetn) ##1 !aresetn |-> pll_level_shift_pd && !master_ref_en;
    endproperty
    a_pll_reset: assert property (p_pll_reset) else $error("bad reset power state");

    property p_strap_follow;
        @(posedge aclk) disable iff (!aresetn)
        (aclken && aresetn) ##1 (aclken && aresetn) ##1 (aclken && aresetn)
        |-> regc_view[prc_pkg::REG_STRAP] == $past(regulator_strap_pin, 2);
    endproperty
    a_strap_follow: assert property (p_strap_follow) else $error("strap not mirrored");

    property p_rsv_zero;
        @(posedge aclk) disable iff (!aresetn)
        (aclken && s_axi_arvalid && s_axi_arready && ar_idx >= prc_pkg::IDX_RSV_LO
         && ar_idx <= prc_pkg::IDX_RSV_HI) |=> (s_axi_rvalid && s_axi_rdata == 32'h00000000);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read nonzero");

    property p_out_mask;
        @(posedge aclk) disable iff (!aresetn)
        (st_r.outc & ~prc_pkg::MASK_OUT) == 8'h00 && (st_r.cm & ~prc_pkg::MASK_CM) == 8'h00;
    endproperty
    a_out_mask: assert property (p_out_mask) else $error("output reserved changed");

    sequence s_wr_cm;
        aclken && wr_go && !st_r.aw_bad && st_r.w_lane && st_r.aw_idx == prc_pkg::IDX_CM;
    endsequence
    property p_cm_write;
        @(posedge aclk) disable iff (!aresetn)
        s_wr_cm |=> low_common_mode == $past(st_r.w_byte[prc_pkg::CM_LOW_VCM])
                    && headphone_half_drive == $past(st_r.w_byte[prc_pkg::CM_HALF_DRV]);
    endproperty
    a_cm_write: assert property (p_cm_write) else $error("common mode write lost");

    property p_resp_one;
        @(posedge aclk) disable iff (!aresetn)
        (aclken && wr_go) |=> s_axi_bvalid;
    endproperty
    a_resp_one: assert property (p_resp_one) else $error("no write response");

    property p_freeze;
        @(posedge aclk) disable iff (!aresetn)
        !aclken |=> $stable(st_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    property p_ref_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_hit && st_r.aw_idx == prc_pkg::IDX_REF)
        |=> master_ref_en == $past(st_r.w_byte[prc_pkg::REF_MASTER])
            && por_pd == $past(st_r.w_byte[prc_pkg::REF_POR_PD])
            && regulator_reference_cell_pd == $past(st_r.w_byte[prc_pkg::REF_BG_PD]);
    endproperty
    a_ref_write: assert property (p_ref_write) else $error("ref write lost");

    property p_reg_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_hit && st_r.aw_idx == prc_pkg::IDX_REG)
        |=> regulator_vsel == $past(st_r.w_byte[prc_pkg::REG_VSEL_LO +: 2])
            && pll_level_shift_pd == $past(st_r.w_byte[prc_pkg::REG_PLL_PD]);
    endproperty
    a_reg_write: assert property (p_reg_write) else $error("regulator write lost");

    property p_play_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_hit && st_r.aw_idx == prc_pkg::IDX_PLAY)
        |=> dac_high_perf == $past(st_r.w_byte[prc_pkg::PLAY_HP_MODE])
            && dac_processing_mode == $past(st_r.w_byte[prc_pkg::PLAY_TIER_LO +: 3]);
    endproperty
    a_play_write: assert property (p_play_write) else $error("playback write lost");

    property p_gain_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_hit && st_r.aw_idx == prc_pkg::IDX_GAIN)
        |=> soft_step_dis == $past(st_r.w_byte[prc_pkg::GAIN_SS_DIS])
            && soft_step_double == $past(st_r.w_byte[prc_pkg::GAIN_SS_DBL]);
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain write lost");

    property p_out_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_hit && st_r.aw_idx == prc_pkg::IDX_OUT)
        |=> headphone_output_en == $past(st_r.w_byte[prc_pkg::OUT_HP_EN])
            && left_analog_input_en == $past(st_r.w_byte[prc_pkg::OUT_LEFT_EN])
            && right_analog_input_en == $past(st_r.w_byte[prc_pkg::OUT_RIGHT_EN]);
    endproperty
    a_out_write: assert property (p_out_write) else $error("output write lost");

    property p_short_follow;
        @(posedge aclk) disable iff (!aresetn)
        (aclken && aresetn) ##1 (aclken && aresetn) ##1 (aclken && aresetn)
        |-> regc_view[prc_pkg::REG_SHORT] == $past(analog_supply_short, 2);
    endproperty
    a_short_follow: assert property (p_short_follow) else $error("short not mirrored");

    property p_rd_bad;
        @(posedge aclk) disable iff (!aresetn)
        (aclken && s_axi_arvalid && s_axi_arready && idx_bad(s_axi_araddr))
        |=> s_axi_rdata == 32'h00000000 && s_axi_rresp == prc_pkg::RESP_SLVERR;
    endproperty
    a_rd_bad: assert property (p_rd_bad) else $error("bad read not refused");

    property p_bad_write;
        @(posedge aclk) disable iff (!aresetn)
        (aclken && wr_go && (st_r.aw_bad || !st_r.w_lane
         || (st_r.aw_idx >= prc_pkg::IDX_RSV_LO && st_r.aw_idx <= prc_pkg::IDX_RSV_HI)))
        |=> $stable({st_r.page, st_r.refc, st_r.regc, st_r.play, st_r.gain, st_r.outc, st_r.cm});
    endproperty
    a_bad_write: assert property (p_bad_write) else $error("ignored write changed state");
endmodule : prc_regs

// file: verification/tb_prc_regs.sv
// Purpose: self-checking bench for the page-one configuration bank
// Assumes: bench is the axi4-lite master; pins change only while the bus is idle
// Notes: a byte model with writable masks predicts every read and every output level
`timescale 1ns/1ns
module tb_prc_regs;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
    logic arv = 1'b0, rry = 1'b0, strap = 1'b0, short_in = 1'b0, en = 1'b1;
    logic [prc_pkg::ADDR_W-1:0] awa = '0, ara = '0;
    logic [31:0] wd = '0;
    logic [3:0] ws = '0;
    logic awr, wr, bv, arr, rv;
    logic [1:0] br, rr;
    logic [31:0] rd;
    logic [24:0] outs;
    logic [7:0] m [0:15];
    int err_total = 0, check_count = 0, cyc = 0;

    always #20 aclk = ~aclk;

    prc_regs prc_regs_i (.aclk(aclk), .aresetn(aresetn), .aclken(en),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .regulator_strap_pin(strap), .analog_supply_short(short_in),
        .page_select(outs[24:17]), .master_ref_en(outs[16]), .por_pd(outs[15]),
        .regulator_reference_cell_pd(outs[14]), .regulator_vsel(outs[13:12]),
        .pll_level_shift_pd(outs[11]), .dac_high_perf(outs[10]),
        .dac_processing_mode(outs[9:7]), .soft_step_dis(outs[6]), .soft_step_double(outs[5]),
        .headphone_output_en(outs[4]), .left_analog_input_en(outs[3]),
        .right_analog_input_en(outs[2]), .low_common_mode(outs[1]),
        .headphone_half_drive(outs[0]));

    task automatic give_verdict();
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : cmp_val

    task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : cmp_resp

    function automatic logic [7:0] wmask(input int i);
        case (i)
            0: return 8'hff;
            1: return prc_pkg::MASK_REF;
            2: return prc_pkg::MASK_REG;
            3: return prc_pkg::MASK_PLAY;
            8: return prc_pkg::MASK_GAIN;
            9: return prc_pkg::MASK_OUT;
            10: return prc_pkg::MASK_CM;
            default: return 8'h00;
        endcase
    endfunction : wmask

    function automatic logic [31:0] exp_outs();
        return {7'h0, m[0], m[1][4], m[1][3], m[1][1], m[2][5:3], m[3][5:2],
            m[8][7:6], m[9][5], m[9][1:0], m[10][6], m[10][2]};
    endfunction : exp_outs

    function automatic logic bad(input logic [5:0] a);
        return (a[1:0] != 2'b00) || (a[5:2] > 4'ha);
    endfunction : bad

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 16; i++) m[i] = 8'h00;
        m[2] = 8'h08;
    endtask : do_reset

    task automatic axi_wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s);
        logic ta, tw, ad, wdn, b;
        logic [1:0] got;
        logic [7:0] dd;
        ad = 1'b0;
        wdn = 1'b0;
        b = 1'b0;
        got = 2'h0;
        // reserved fields are only ever written with their reset values
        dd = (d & wmask(a[5:2]))
            | ((a[5:2] == 4'h2 ? prc_pkg::RST_REG : 8'h00) & ~wmask(a[5:2]));
        @(posedge aclk);
        awa <= a;
        awv <= 1'b1;
        wd <= {24'($urandom), dd};
        ws <= s;
        wv <= 1'b1;
        bry <= 1'b1;
        while (!(ad && wdn)) begin
            @(negedge aclk);
            ta = awv && (awr === 1'b1);
            tw = wv && (wr === 1'b1);
            @(posedge aclk);
            if (ta) begin
                awv <= 1'b0;
                ad = 1'b1;
            end
            if (tw) begin
                wv <= 1'b0;
                wdn = 1'b1;
            end
        end
        while (!b) begin
            @(negedge aclk);
            b = (bv === 1'b1);
            got = br;
            @(posedge aclk);
        end
        bry <= 1'b0;
        if (bad(a)) begin
            cmp_resp("bresp", prc_pkg::RESP_SLVERR, got);
        end else begin
            cmp_resp("bresp", prc_pkg::RESP_OKAY, got);
            if (s[0]) m[a[5:2]] = (m[a[5:2]] & ~wmask(a[5:2])) | (d & wmask(a[5:2]));
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [5:0] a);
        logic t, r;
        logic [31:0] d;
        logic [1:0] p;
        logic [7:0] e;
        r = 1'b0;
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        while (!r) begin
            @(negedge aclk);
            t = arv && (arr === 1'b1);
            r = (rv === 1'b1);
            d = rd;
            p = rr;
            @(posedge aclk);
            if (t) arv <= 1'b0;
        end
        rry <= 1'b0;
        e = (a[5:2] == 4'h2) ? (m[2] | 8'h04 | {6'h00, short_in, strap}) : m[a[5:2]];
        if (bad(a)) begin
            cmp_resp("rresp", prc_pkg::RESP_SLVERR, p);
            cmp_val("rdata", 32'h0, d);
        end else begin
            cmp_resp("rresp", prc_pkg::RESP_OKAY, p);
            cmp_val("rdata", {24'h0, e}, d);
        end
        cmp_val("outputs", exp_outs(), {7'h0, outs});
    endtask : axi_rd

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(78));
        do_reset();
        for (int i = 0; i < 16; i++) axi_rd(6'(i * 4));
        for (int i = 0; i < 11; i++) begin
            axi_wr(6'(i * 4), 8'hff, 4'h1);
            axi_rd(6'(i * 4));
        end
        for (int c = 0; c < 8; c++) begin
            axi_wr(6'h0c, 8'(c << 2), 4'hf);
            axi_rd(6'h0c);
            axi_wr(6'h08, 8'((c % 4) << 4), 4'h1);
            axi_rd(6'h08);
        end
        axi_wr(6'h05, 8'h00, 4'h1);
        axi_rd(6'h06);
        for (int k = 0; k < 60; k++) begin
            strap <= 1'($urandom);
            short_in <= 1'($urandom);
            repeat (4) @(posedge aclk);
            axi_wr(6'($urandom_range(0, 47)) & (($urandom % 6 != 0) ? 6'h3c : 6'h3f),
                8'($urandom), 4'($urandom));
            axi_rd(6'h08);
            axi_rd(6'($urandom_range(0, 11) * 4));
        end
        // a write offered while disabled must wait and leave every output alone
        en <= 1'b0;
        fork
            axi_wr(6'h24, 8'h23, 4'h1);
            begin
                repeat (6) @(posedge aclk);
                @(negedge aclk);
                cmp_val("frozen outputs", exp_outs(), {7'h0, outs});
                cmp_val("frozen awready", 32'h0, {31'h0, awr});
                @(posedge aclk);
                en <= 1'b1;
            end
        join
        axi_rd(6'h24);
        do_reset();
        for (int i = 0; i < 11; i++) axi_rd(6'(i * 4));
        give_verdict();
    end
endmodule : tb_prc_regs
